// file: design/pcc_channel_ctrl.sv
// Serial-programmed control bank of a dual pin-electronics channel
`timescale 1ns/1ns
`default_nettype none
`include "pcc_defines.svh"

module pcc_channel_ctrl
  import pcc_pkg::*;
#(
  parameter int N_LEVEL = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Driver inputs and state
  input wire logic [1:0] driver_data_input,
  input wire logic [1:0] driver_receive_input,
  output pcc_drv_state_t [1:0] drv_state,
  output pcc_drv_ctrl_t [1:0] drv_ctrl,
  // Comparators
  input wire logic [1:0] win_cmp_hi,
  input wire logic [1:0] win_cmp_lo,
  input wire logic diff_cmp_hi,
  input wire logic diff_cmp_lo,
  output logic [1:0] cmp_out_hi,
  output logic [1:0] cmp_out_lo,
  output pcc_cmp_ctrl_t [1:0] cmp_ctrl,
  // Load and converter levels
  output logic [1:0][15:0] load_ctrl,
  output logic [1:0][15:0][15:0] level_out
);

  // Level index lives in four address bits, so only 1..15 can be decoded
  if (N_LEVEL < 1 || N_LEVEL > 15) begin : g_bad_level
    $error("N_LEVEL must lie in 1..15");
  end

  // ---------------------------------------------------------------
  // Reset and serial framing
  // ---------------------------------------------------------------
  logic soft_rst;
  logic srst;
  logic sclk_q;
  logic [`PCC_CNT_W-1:0] bit_cnt;
  logic [`PCC_FRAME_BITS-1:0] shreg;
  logic frame_done;
  logic hdr_done;
  logic [15:0] rd_sh;
  logic rise;
  logic fall;
  pcc_hdr_t hdr;
  pcc_hdr_t hdr_early;
  logic [15:0] wdata;
  logic wr;
  logic [1:0][15:0] lu_ctrl;
  logic [15:0] sp_ctrl;
  logic [1:0][15:0][15:0] lvl_buf;
  logic [1:0][15:0][15:0] coef_m;
  logic [1:0][15:0][15:0] coef_c;
  logic cal_en;

  assign srst = rst | soft_rst;
  assign rise = spi_sclk & ~sclk_q;
  assign fall = ~spi_sclk & sclk_q;
  assign hdr = pcc_hdr_t'(shreg[`PCC_FRAME_BITS-1:`PCC_DATA_BITS]);
  assign hdr_early = pcc_hdr_t'(shreg[`PCC_HDR_BITS-1:0]);
  assign wdata = shreg[`PCC_DATA_BITS-1:0];
  assign wr = frame_done & ~hdr.rd;
  assign cal_en = lu_ctrl[0][`PCC_LU_CAL_EN];

  always_ff @(posedge clk) begin
    if (rst) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr && hdr.ch[0] && hdr.addr == `PCC_ADDR_SERIAL_PORT_CONTROL
        && wdata[`PCC_SP_SOFT_RESET];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q <= 1'b0;
      bit_cnt <= '0;
      shreg <= '0;
      frame_done <= 1'b0;
      hdr_done <= 1'b0;
    end else begin
      sclk_q <= spi_sclk;
      frame_done <= ~spi_cs_n && rise && bit_cnt == 5'(`PCC_FRAME_BITS - 1);
      hdr_done <= ~spi_cs_n && rise && bit_cnt == 5'(`PCC_HDR_BITS - 1);
      if (spi_cs_n) begin
        bit_cnt <= '0;
      end else if (rise && bit_cnt != 5'(`PCC_FRAME_BITS)) begin
        shreg <= {shreg[`PCC_FRAME_BITS-2:0], spi_sdi};
        bit_cnt <= bit_cnt + 5'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------
  function automatic logic [15:0] rd_word(input pcc_hdr_t h);
    int c;
    c = h.ch[0] ? 0 : 1;
    rd_word = `PCC_RST_ZERO;
    if (h.addr[6:4] == `PCC_LVL_GROUP && h.addr[3:0] != 4'h0
        && int'(h.addr[3:0]) <= N_LEVEL) begin
      rd_word = lvl_buf[c][h.addr[3:0]];
    end else if (h.addr == `PCC_ADDR_LEVEL_UPDATE_CONTROL) begin
      rd_word = lu_ctrl[c];
    end else if (h.addr == `PCC_ADDR_SERIAL_PORT_CONTROL) begin
      rd_word = (c == 0) ? sp_ctrl : `PCC_RST_ZERO;
    end else if (h.addr == `PCC_ADDR_DRIVER_CONTROL) begin
      rd_word = drv_ctrl[c];
    end else if (h.addr == `PCC_ADDR_COMPARATOR_CONTROL) begin
      rd_word = cmp_ctrl[c];
    end else if (h.addr == `PCC_ADDR_ACTIVE_LOAD_CONTROL) begin
      rd_word = load_ctrl[c];
    end else if (h.addr[6:4] == `PCC_M_GROUP && h.addr[3:0] != 4'h0
                 && int'(h.addr[3:0]) <= N_LEVEL) begin
      rd_word = coef_m[c][h.addr[3:0]];
    end else if (h.addr[6:4] == `PCC_C_GROUP && h.addr[3:0] != 4'h0
                 && int'(h.addr[3:0]) <= N_LEVEL) begin
      rd_word = coef_c[c][h.addr[3:0]];
    end
  endfunction

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_sh <= '0;
      spi_sdo <= 1'b0;
    end else if (hdr_done) begin
      rd_sh <= hdr_early.rd ? rd_word(hdr_early) : `PCC_RST_ZERO;
    end else if (fall && !spi_cs_n && bit_cnt >= 5'(`PCC_HDR_BITS)) begin
      spi_sdo <= rd_sh[15];
      rd_sh <= {rd_sh[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      spi_sdo_oe <= 1'b1;
    end else begin
      spi_sdo_oe <= sp_ctrl[`PCC_SP_TRISTATE] ? ~spi_cs_n : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      lu_ctrl <= '0;
      sp_ctrl <= `PCC_RST_ZERO;
      drv_ctrl <= '0;
      cmp_ctrl <= {2{`PCC_RST_CMP}};
      load_ctrl <= {2{`PCC_RST_LOAD}};
    end else if (wr) begin
      if (hdr.addr == `PCC_ADDR_LEVEL_UPDATE_CONTROL) begin
        // Strobe bit is never stored, so it reads zero
        if (hdr.ch[0]) begin
          lu_ctrl[0] <= wdata & `PCC_LU_MASK_CH0;
        end
        if (hdr.ch[1]) begin
          lu_ctrl[1] <= wdata & `PCC_LU_MASK_CH1;
        end
      end else if (hdr.addr == `PCC_ADDR_SERIAL_PORT_CONTROL) begin
        if (hdr.ch[0]) begin
          sp_ctrl <= wdata & `PCC_SP_MASK_CH0;
        end
      end else if (hdr.addr == `PCC_ADDR_DRIVER_CONTROL) begin
        for (int c = 0; c < 2; c++) begin
          if (hdr.ch[c]) begin
            drv_ctrl[c] <= pcc_drv_ctrl_t'(wdata & `PCC_DRV_MASK);
          end
        end
      end else if (hdr.addr == `PCC_ADDR_COMPARATOR_CONTROL) begin
        // Hysteresis and preemphasis codes drive the analog side as-is
        if (hdr.ch[0]) begin
          cmp_ctrl[0] <= pcc_cmp_ctrl_t'(wdata & `PCC_CMP_MASK_CH0);
        end
        if (hdr.ch[1]) begin
          cmp_ctrl[1] <= pcc_cmp_ctrl_t'(wdata & `PCC_CMP_MASK_CH1);
        end
      end else if (hdr.addr == `PCC_ADDR_ACTIVE_LOAD_CONTROL) begin
        for (int c = 0; c < 2; c++) begin
          if (hdr.ch[c]) begin
            load_ctrl[c] <= wdata & `PCC_LOAD_MASK;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Calibration coefficients
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      coef_m <= {32{`PCC_RST_M}};
      coef_c <= {32{`PCC_RST_C}};
    end else if (wr && hdr.addr[3:0] != 4'h0 && int'(hdr.addr[3:0]) <= N_LEVEL) begin
      for (int c = 0; c < 2; c++) begin
        if (hdr.ch[c] && hdr.addr[6:4] == `PCC_M_GROUP) begin
          coef_m[c][hdr.addr[3:0]] <= wdata;
        end
        if (hdr.ch[c] && hdr.addr[6:4] == `PCC_C_GROUP) begin
          coef_c[c][hdr.addr[3:0]] <= wdata;
        end
      end
    end
  end

  // Gain in units of 1/65536, offset centred on 0x8000, result saturated
  function automatic logic [15:0] cal_f(input logic [15:0] d, input logic [15:0] m,
                                        input logic [15:0] c);
    logic [31:0] prod;
    logic signed [18:0] sum;
    prod = d * m;
    sum = $signed({3'b000, prod[31:16]}) + $signed({3'b000, c}) - 19'sh08000;
    if (sum < 19'sh00000) begin
      cal_f = 16'h0000;
    end else if (sum > 19'sh0FFFF) begin
      cal_f = 16'hFFFF;
    end else begin
      cal_f = sum[15:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // Level buffers and converter values
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      lvl_buf <= {32{`PCC_RST_LEVEL}};
      level_out <= {32{`PCC_RST_LEVEL}};
    end else if (wr) begin
      for (int c = 0; c < 2; c++) begin
        if (hdr.ch[c] && hdr.addr[6:4] == `PCC_LVL_GROUP && hdr.addr[3:0] != 4'h0
            && int'(hdr.addr[3:0]) <= N_LEVEL) begin
          if (cal_en) begin
            lvl_buf[c][hdr.addr[3:0]] <= cal_f(wdata, coef_m[c][hdr.addr[3:0]],
                                               coef_c[c][hdr.addr[3:0]]);
            if (!lu_ctrl[c][`PCC_LU_DEFERRED]) begin
              level_out[c][hdr.addr[3:0]] <= cal_f(wdata, coef_m[c][hdr.addr[3:0]],
                                                   coef_c[c][hdr.addr[3:0]]);
            end
          end else begin
            lvl_buf[c][hdr.addr[3:0]] <= wdata;
            if (!lu_ctrl[c][`PCC_LU_DEFERRED]) begin
              level_out[c][hdr.addr[3:0]] <= wdata;
            end
          end
        end
        if (hdr.ch[c] && hdr.addr == `PCC_ADDR_LEVEL_UPDATE_CONTROL
            && wdata[`PCC_LU_STROBE] && lu_ctrl[c][`PCC_LU_DEFERRED]) begin
          level_out[c] <= lvl_buf[c];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Driver state per channel
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_drv
    logic dat_sel;
    logic rcv_sel;
    assign dat_sel = drv_ctrl[g].data_src ? driver_data_input[1-g]
                                          : driver_data_input[g];
    assign rcv_sel = drv_ctrl[g].rcv_src ? driver_receive_input[1-g]
                                         : driver_receive_input[g];
    always_ff @(posedge clk) begin
      if (srst) begin
        drv_state[g] <= PCC_DRV_OFF;
      end else if (!drv_ctrl[g].enable) begin
        drv_state[g] <= PCC_DRV_OFF;
      end else if (drv_ctrl[g].force_on) begin
        // Force wins over term select and the fast inputs
        case (drv_ctrl[g].force_state)
          2'b00: drv_state[g] <= PCC_DRV_LOW;
          2'b01: drv_state[g] <= PCC_DRV_HIGH;
          2'b10: drv_state[g] <= PCC_DRV_HIZ;
          default: drv_state[g] <= PCC_DRV_TERM;
        endcase
      end else if (rcv_sel) begin
        drv_state[g] <= drv_ctrl[g].term_sel ? PCC_DRV_TERM : PCC_DRV_HIZ;
      end else begin
        drv_state[g] <= dat_sel ? PCC_DRV_HIGH : PCC_DRV_LOW;
      end
    end
  end

  // ---------------------------------------------------------------
  // Comparator output routing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      cmp_out_hi <= '0;
      cmp_out_lo <= '0;
    end else begin
      cmp_out_hi[0] <= cmp_ctrl[0].diff_on ? diff_cmp_hi : win_cmp_hi[0];
      cmp_out_lo[0] <= cmp_ctrl[0].diff_on ? diff_cmp_lo : win_cmp_lo[0];
      cmp_out_hi[1] <= win_cmp_hi[1];
      cmp_out_lo[1] <= win_cmp_lo[1];
    end
  end

endmodule

`default_nettype wire

// file: design/pcc_defines.svh
// Register offsets, field positions, masks and reset values of the channel control bank
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH

// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define PCC_HDR_BITS 10
`define PCC_DATA_BITS 16
`define PCC_FRAME_BITS 26
`define PCC_CNT_W 5

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define PCC_ADDR_LEVEL_UPDATE_CONTROL 7'h11
`define PCC_ADDR_SERIAL_PORT_CONTROL 7'h12
`define PCC_ADDR_DRIVER_CONTROL 7'h19
`define PCC_ADDR_COMPARATOR_CONTROL 7'h1A
`define PCC_ADDR_ACTIVE_LOAD_CONTROL 7'h1B
`define PCC_LVL_GROUP 3'h0
`define PCC_M_GROUP 3'h2
`define PCC_C_GROUP 3'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PCC_LU_STROBE 2
`define PCC_LU_DEFERRED 1
`define PCC_LU_CAL_EN 0
`define PCC_SP_TRISTATE 1
`define PCC_SP_SOFT_RESET 0

// ---------------------------------------------------------------
// Writable masks per channel (reserved and self-clearing bits excluded)
// ---------------------------------------------------------------
`define PCC_LU_MASK_CH0 16'h0003
`define PCC_LU_MASK_CH1 16'h0002
`define PCC_SP_MASK_CH0 16'h0002
`define PCC_DRV_MASK 16'hFE1F
`define PCC_CMP_MASK_CH0 16'hFF7F
`define PCC_CMP_MASK_CH1 16'hFF70
`define PCC_LOAD_MASK 16'hFFFF

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PCC_RST_ZERO 16'h0000
`define PCC_RST_CMP 16'hFF00
`define PCC_RST_LOAD 16'h0003
`define PCC_RST_LEVEL 16'h4000
`define PCC_RST_M 16'hFFFF
`define PCC_RST_C 16'h8000

`endif

// file: design/pcc_pkg.sv
// Types shared by the channel control bank
package pcc_pkg;

  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [1:0] ch;
  } pcc_hdr_t;

  typedef struct packed {
    logic ext_data;
    logic data_src;
    logic ext_rcv;
    logic rcv_src;
    logic [2:0] preemph;
    logic [3:0] rsvd;
    logic term_sel;
    logic [1:0] force_state;
    logic force_on;
    logic enable;
  } pcc_drv_ctrl_t;

  typedef struct packed {
    logic [3:0] win_hyst;
    logic [3:0] diff_hyst;
    logic rsvd;
    logic [2:0] win_preemph;
    logic [2:0] diff_preemph;
    logic diff_on;
  } pcc_cmp_ctrl_t;

  typedef enum logic [4:0] {
    PCC_DRV_OFF  = 5'b00001,
    PCC_DRV_LOW  = 5'b00010,
    PCC_DRV_HIGH = 5'b00100,
    PCC_DRV_TERM = 5'b01000,
    PCC_DRV_HIZ  = 5'b10000
  } pcc_drv_state_t;

endpackage

// file: sim/pcc_channel_ctrl_checker.sv
// Concurrent checks on the channel control bank ports
`timescale 1ns/1ns
`default_nettype none
module pcc_channel_ctrl_checker
  import pcc_pkg::*;
#(
  parameter int N_LEVEL = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  // Driver
  input wire logic [1:0] driver_data_input,
  input wire logic [1:0] driver_receive_input,
  input wire pcc_drv_state_t [1:0] drv_state,
  input wire pcc_drv_ctrl_t [1:0] drv_ctrl,
  // Comparators
  input wire logic [1:0] win_cmp_hi,
  input wire logic [1:0] win_cmp_lo,
  input wire logic diff_cmp_hi,
  input wire logic diff_cmp_lo,
  input wire logic [1:0] cmp_out_hi,
  input wire logic [1:0] cmp_out_lo,
  input wire pcc_cmp_ctrl_t [1:0] cmp_ctrl,
  // Load and levels
  input wire logic [1:0][15:0] load_ctrl,
  input wire logic [1:0][15:0][15:0] level_out
);
  pcc_drv_state_t exp0;
  logic [1:0] sel0;

  function automatic pcc_drv_state_t drv_exp(pcc_drv_ctrl_t c, logic [1:0] d, logic [1:0] r);
    logic dv;
    logic rv;
    dv = c.data_src ? d[1] : d[0];
    rv = c.rcv_src ? r[1] : r[0];
    if (!c.enable) return PCC_DRV_OFF;
    if (c.force_on) begin
      case (c.force_state)
        2'b00: return PCC_DRV_LOW;
        2'b01: return PCC_DRV_HIGH;
        2'b10: return PCC_DRV_HIZ;
        default: return PCC_DRV_TERM;
      endcase
    end
    if (rv) return c.term_sel ? PCC_DRV_TERM : PCC_DRV_HIZ;
    return dv ? PCC_DRV_HIGH : PCC_DRV_LOW;
  endfunction

  // Expected channel 0 state one cycle after its causes
  always_ff @(posedge clk) exp0 <= drv_exp(drv_ctrl[0], driver_data_input, driver_receive_input);
  assign sel0 = cmp_ctrl[0].diff_on ? {diff_cmp_hi, diff_cmp_lo} : {win_cmp_hi[0], win_cmp_lo[0]};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----
  // Assertions
  // ----
  a_oe_reset: assert property (disable iff (1'b0) rst |=> spi_sdo_oe && !spi_sdo)
    else $error("serial output not idle after reset");
  a_oe_frame: assert property ($fell(spi_cs_n) |=> spi_sdo_oe [*8])
    else $error("serial output not driven while selected");
  a_oe_fall: assert property ($fell(spi_sdo_oe) |-> $past(spi_cs_n))
    else $error("serial output released while selected");
  a_drv_table: assert property ($stable(drv_ctrl[0]) |-> drv_state[0] == exp0)
    else $error("channel 0 driver state wrong");
  a_drv_term: assert property (drv_ctrl[1].enable && drv_ctrl[1].force_on &&
      drv_ctrl[1].force_state == 2'b11 ##1 $stable(drv_ctrl[1]) |-> drv_state[1] == PCC_DRV_TERM)
    else $error("forced termination not held");
  a_drv_off: assert property (!drv_ctrl[1].enable ##1 $stable(drv_ctrl[1]) |->
      drv_state[1] == PCC_DRV_OFF)
    else $error("disabled driver not off");
  a_cmp_route: assert property ({cmp_out_hi[0], cmp_out_lo[0]} == $past(sel0))
    else $error("channel 0 comparator output from wrong source");
  a_cmp_pass: assert property (cmp_out_hi[1] == $past(win_cmp_hi[1]) &&
      cmp_out_lo[1] == $past(win_cmp_lo[1]))
    else $error("channel 1 comparator output wrong");
  a_regs_quiet: assert property (!$stable(level_out) || !$stable(load_ctrl) |->
      !$past(spi_cs_n))
    else $error("register changed outside a frame");

  c_diff: cover property (cmp_ctrl[0].diff_on && diff_cmp_hi);
  c_term: cover property (drv_state[1] == PCC_DRV_TERM);
  c_hiz: cover property ($fell(spi_sdo_oe));
endmodule
`default_nettype wire

// file: sim/pcc_spi_host.sv
// Serial host model that frames register accesses
`timescale 1ns/1ns
`default_nettype none
module pcc_spi_host
  import pcc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Serial port
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  int ph = 2;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----
  // One frame, header then data, MSB first
  // ----
  task automatic frame(input pcc_hdr_t h, input logic [15:0] w, output logic [15:0] r);
    logic [25:0] b;
    b = {h, w};
    r = 16'h0000;
    tk(1);
    spi_cs_n = 1'b0;
    for (int k = 25; k >= 0; k--) begin
      spi_sdi = b[k];
      tk(ph);
      if (k < 16) r = {r[14:0], spi_sdo};
      spi_sclk = 1'b1;
      tk(ph);
      spi_sclk = 1'b0;
    end
    tk(5);
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    tk(1);
  endtask
endmodule
`default_nettype wire

// file: sim/pin_channel_control_registers_tb.sv
// Self-checking bench of the channel control bank
`timescale 1ns/1ns
`default_nettype none
`include "pcc_defines.svh"
module pin_channel_control_registers_tb
  import pcc_pkg::*;
;
  localparam logic [1:0] CH0 = 2'b01;
  localparam logic [1:0] CH1 = 2'b10;
  localparam logic [6:0] LU = `PCC_ADDR_LEVEL_UPDATE_CONTROL;
  localparam logic [6:0] SP = `PCC_ADDR_SERIAL_PORT_CONTROL;
  localparam logic [6:0] DRV = `PCC_ADDR_DRIVER_CONTROL;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] dat = 2'b00, rcv = 2'b00, whi = 2'b00, wlo = 2'b00;
  logic dhi = 1'b0, dlo = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe;
  logic [1:0] co_hi, co_lo;
  pcc_drv_state_t [1:0] drv_state;
  pcc_drv_ctrl_t [1:0] drv_ctrl;
  pcc_cmp_ctrl_t [1:0] cmp_ctrl;
  logic [1:0][15:0] load_ctrl;
  logic [1:0][15:0][15:0] level_out;
  logic [15:0] v, r;
  int bad_count = 0;
  int num_checks = 0;
  logic [6:0] radr [3] = '{DRV, `PCC_ADDR_COMPARATOR_CONTROL, `PCC_ADDR_ACTIVE_LOAD_CONTROL};
  // Driver control, data pair, receive pair, expected channel 1 state
  logic [24:0] dtab [12] = '{
    {16'h0000, 2'b10, 2'b00, PCC_DRV_OFF},
    {16'h0001, 2'b10, 2'b00, PCC_DRV_HIGH},
    {16'h0001, 2'b00, 2'b10, PCC_DRV_HIZ},
    {16'h0011, 2'b00, 2'b10, PCC_DRV_TERM},
    {16'h000F, 2'b00, 2'b10, PCC_DRV_TERM},
    {16'h0007, 2'b00, 2'b00, PCC_DRV_HIGH},
    {16'h0003, 2'b10, 2'b00, PCC_DRV_LOW},
    {16'h000B, 2'b10, 2'b00, PCC_DRV_HIZ},
    {16'h4001, 2'b01, 2'b00, PCC_DRV_HIGH},
    {16'h1001, 2'b00, 2'b01, PCC_DRV_HIZ},
    {16'h8E01, 2'b10, 2'b00, PCC_DRV_HIGH},
    {16'h000E, 2'b10, 2'b00, PCC_DRV_OFF}
  };

  pcc_channel_ctrl pcc_channel_ctrl_i (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .driver_data_input(dat),
    .driver_receive_input(rcv), .drv_state(drv_state), .drv_ctrl(drv_ctrl), .win_cmp_hi(whi),
    .win_cmp_lo(wlo), .diff_cmp_hi(dhi), .diff_cmp_lo(dlo), .cmp_out_hi(co_hi),
    .cmp_out_lo(co_lo), .cmp_ctrl(cmp_ctrl), .load_ctrl(load_ctrl), .level_out(level_out));
  pcc_spi_host pcc_spi_host_i (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----
  // Helpers
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] c, input logic [6:0] a, input logic [15:0] d);
    logic [15:0] x;
    pcc_spi_host_i.frame(pcc_hdr_t'{1'b0, a, c}, d, x);
  endtask
  task automatic rd(input logic [1:0] c, input logic [6:0] a, output logic [15:0] x);
    pcc_spi_host_i.frame(pcc_hdr_t'{1'b1, a, c}, 16'h0000, x);
  endtask
  function automatic logic [15:0] rmask(int i, int c);
    if (i == 0) return `PCC_DRV_MASK;
    if (i == 1) return c ? `PCC_CMP_MASK_CH1 : `PCC_CMP_MASK_CH0;
    return `PCC_LOAD_MASK;
  endfunction
  function automatic logic [15:0] cal(logic [15:0] d, logic [15:0] m, logic [15:0] c);
    int t;
    t = int'((32'(d) * 32'(m)) >> 16) + int'(c) - int'(16'h8000);
    return (t < 0) ? 16'h0000 : (t > int'(16'hFFFF)) ? 16'hFFFF : 16'(t);
  endfunction
  task automatic complete_run();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(86117));
    tick(10);
    rst = 1'b0;
    tick(1);
    check(drv_ctrl[1], `PCC_RST_ZERO);
    check(cmp_ctrl[0], `PCC_RST_CMP);
    check(load_ctrl[1], `PCC_RST_LOAD);
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 2; c++) begin
        pcc_spi_host_i.ph = 2 + c;
        v = 16'($urandom);
        wr(2'(1 << c), radr[i], v);
        rd(2'(1 << c), radr[i], r);
        check(r, v & rmask(i, c));
      end
    end
    wr(CH0, 7'h13, 16'hFFFF);
    rd(CH0, 7'h13, r);
    check(r, 16'h0000);
    wr(CH1, LU, 16'h0001);
    rd(CH0, LU, r);
    check(r, 16'h0000);
    wr(2'b11, radr[1], 16'hFFFF);
    check(cmp_ctrl[0], `PCC_CMP_MASK_CH0);
    check(cmp_ctrl[1], `PCC_CMP_MASK_CH1);
    for (int m = 1; m >= 0; m--) begin
      wr(CH0, radr[1], 16'(m));
      repeat (10) begin
        {whi, wlo, dhi, dlo} = 6'($urandom);
        tick(1);
        check({co_hi, co_lo}, m ? {whi[1], dhi, wlo[1], dlo} : {whi, wlo});
      end
    end
    {whi, wlo, dhi, dlo} = 6'h00;
    foreach (dtab[i]) begin
      wr(CH1, DRV, dtab[i][24:9]);
      {dat, rcv} = dtab[i][8:5];
      tick(2);
      check(drv_state[1], dtab[i][4:0]);
    end
    repeat (6) begin
      v = 16'($urandom);
      wr(CH0, DRV, v);
      check(drv_ctrl[0], v & `PCC_DRV_MASK);
      repeat (8) begin
        {dat, rcv} = 4'($urandom);
        tick(1);
      end
    end
    wr(CH0, LU, 16'h0002);
    v = 16'($urandom);
    wr(2'b11, 7'h03, v);
    check(level_out[0][3], `PCC_RST_LEVEL);
    check(level_out[1][3], v);
    wr(CH0, 7'h05, ~v);
    wr(CH1, LU, 16'h0004);
    check(level_out[0][5], `PCC_RST_LEVEL);
    wr(CH0, LU, 16'h0006);
    check(level_out[0][3], v);
    check(level_out[0][5], ~v);
    rd(CH0, LU, r);
    check(r, 16'h0002);
    wr(CH0, LU, 16'h0001);
    wr(2'b11, 7'h21, 16'h8000);
    wr(2'b11, 7'h31, 16'h8010);
    for (int k = 0; k < 4; k++) begin
      v = k ? 16'($urandom) : 16'hFFFF;
      wr(CH1, 7'h01, v);
      check(level_out[1][1], cal(v, 16'h8000, 16'h8010));
    end
    rd(CH1, 7'h01, r);
    check(r, cal(v, 16'h8000, 16'h8010));
    rd(CH0, 7'h31, r);
    check(r, 16'h8010);
    wr(CH0, LU, 16'h0000);
    wr(CH1, 7'h01, v);
    check(level_out[1][1], v);
    wr(CH0, SP, 16'h0002);
    tick(2);
    check(16'(sdo_oe), 16'h0000);
    rd(CH0, SP, r);
    check(r, 16'h0002);
    wr(CH0, radr[2], 16'h1234);
    wr(CH1, SP, 16'h0001);
    check(load_ctrl[0], 16'h1234);
    wr(CH0, SP, 16'h0003);
    tick(2);
    check(16'(sdo_oe), 16'h0001);
    check(load_ctrl[0], `PCC_RST_LOAD);
    check(level_out[1][1], `PCC_RST_LEVEL);
    rd(CH0, SP, r);
    check(r, 16'h0000);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule

bind pcc_channel_ctrl pcc_channel_ctrl_checker #(.N_LEVEL(N_LEVEL)) pcc_channel_ctrl_checker_i (
  .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
  .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .driver_data_input(driver_data_input),
  .driver_receive_input(driver_receive_input), .drv_state(drv_state), .drv_ctrl(drv_ctrl),
  .win_cmp_hi(win_cmp_hi), .win_cmp_lo(win_cmp_lo), .diff_cmp_hi(diff_cmp_hi),
  .diff_cmp_lo(diff_cmp_lo), .cmp_out_hi(cmp_out_hi), .cmp_out_lo(cmp_out_lo),
  .cmp_ctrl(cmp_ctrl), .load_ctrl(load_ctrl), .level_out(level_out));
`default_nettype wire
